// ### design/fpu_top.v
/*
 Floating point coprocessor: instruction queue, arithmetic and transfer
 pipes of seven stages, register file, control/status and AXI4-Lite slave.
 Assumes instructions and integer operands come over the bus in program
 order, and a memory that returns load data in the same cycle as mem_re.
*/
`timescale 1ns/100ps
`include "fpu_regs.vh"

module fpu_top #(
	parameter [1:0] CLK_RATIO = `FPU_RATIO_TWO_THIRDS // Unit clock ratio option
) (
	input wire aclk, // Clock
	input wire aresetn, // Synchronous reset, low
	input wire [7:0] awaddr, // Write address
	input wire awvalid, // Write address valid
	output reg awready, // Write address ready
	input wire [31:0] wdata, // Write data
	input wire [3:0] wstrb, // Byte enables
	input wire wvalid, // Write data valid
	output reg wready, // Write data ready
	output reg [1:0] bresp, // Write response
	output reg bvalid, // Write response valid
	input wire bready, // Write response ready
	input wire [7:0] araddr, // Read address
	input wire arvalid, // Read address valid
	output reg arready, // Read address ready
	output reg [31:0] rdata, // Read data
	output reg [1:0] rresp, // Read response
	output reg rvalid, // Read data valid
	input wire rready, // Read data ready
	input wire big_endian, // Core byte order
	output reg mem_re, // Memory read pulse
	output reg mem_we, // Memory write pulse
	output reg [31:0] mem_addr, // Memory byte address
	output reg [63:0] mem_wdata, // Memory write data
	input wire [63:0] mem_rdata, // Load data, same cycle as mem_re
	output reg fp_exception // Trap to core, level
);
	reg [31:0] queue [0:3];
	reg [63:0] fp_clock_ratio_field [0:31];
	reg [1:0] q_rd, q_wr;
	reg [2:0] q_cnt;
	reg [31:0] busy;
	reg [31:0] gpr_a, gpr_b, xfer_out;
	reg [7:0] fcc;
	reg [1:0] rm;
	reg [4:0] flags, enables;
	reg [5:0] cause;
	reg notrap;
	reg [1:0] div_cnt;
	reg fpu_en;
	reg [6:0] ap_v, ap_ccw, ap_ccv, tp_v, tp_x;
	reg [4:0] ap_dst [0:6];
	reg [4:0] tp_dst [0:6];
	reg [1:0] ap_wm [0:6];
	reg [1:0] tp_wm [0:6];
	reg [63:0] ap_d [0:6];
	reg [63:0] tp_d [0:6];
	reg [5:0] ap_c [0:6];
	reg [2:0] ap_cci [0:6];
	reg ld_pend, ld_w32;
	reg aw_held, w_held;
	reg [7:0] aw_a;
	reg [31:0] w_d;
	reg [3:0] w_s;
	integer i;
	integer j;

	function hz;
		input [31:0] ins;
		input [31:0] bsy;
		input pipe_busy;
		begin
			hz = bsy[ins[`FPU_I_FS]] | bsy[ins[`FPU_I_FT]] | bsy[ins[`FPU_I_FR]] |
				bsy[ins[`FPU_I_FD]] | (ins[`FPU_I_OP] == `FPU_OP_MOVF && pipe_busy);
		end
	endfunction

	function [63:0] wmerge;
		input [63:0] old;
		input [63:0] nv;
		input [1:0] wm;
		begin
			case (wm)
			`FPU_WM_FULL: wmerge = nv;
			`FPU_WM_LOW: wmerge = {old[63:32], nv[31:0]};
			`FPU_WM_HIGH: wmerge = {nv[63:32], old[31:0]};
			default: wmerge = old;
			endcase
		end
	endfunction

	function [31:0] smerge;
		input [31:0] old;
		input [31:0] nv;
		input [3:0] s;
		begin
			smerge = (old & ~{{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}) |
				(nv & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}});
		end
	endfunction

	function [63:0] border;
		input [63:0] d;
		input w32;
		input be;
		integer k;
		begin
			border = d;
			for (k = 0; k < 8; k = k + 1) begin
				if (be && !w32)
					border[8*k +: 8] = d[8*(7-k) +: 8];
				else if (be && k < 4)
					border[8*k +: 8] = d[8*(3-k) +: 8];
				else if (be)
					border[8*k +: 8] = 8'h00;
			end
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 2'h0;
			fpu_en <= 1'b0;
		end else if (CLK_RATIO == `FPU_RATIO_TWO_THIRDS) begin
			div_cnt <= (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
			fpu_en <= (div_cnt != 2'h2);
		end else if (CLK_RATIO == `FPU_RATIO_HALF) begin
			div_cnt <= {1'b0, ~div_cnt[0]};
			fpu_en <= div_cnt[0];
		end else begin
			div_cnt <= 2'h0;
			fpu_en <= 1'b1;
		end
	end

	wire [31:0] h0 = queue[q_rd];
	wire [31:0] h1 = queue[q_rd + 2'h1];
	wire x0 = h0[`FPU_I_XFER];
	wire x1 = h1[`FPU_I_XFER];
	wire dep = (h0[`FPU_I_FD] == h1[`FPU_I_FS]) | (h0[`FPU_I_FD] == h1[`FPU_I_FT]) |
		(h0[`FPU_I_FD] == h1[`FPU_I_FR]) | (h0[`FPU_I_FD] == h1[`FPU_I_FD]);
	wire issue0 = fpu_en && q_cnt != 3'h0 && !fp_exception && !hz(h0, busy, |ap_v);
	wire issue1 = issue0 && q_cnt > 3'h1 && x0 != x1 && !dep && !hz(h1, busy, |ap_v);
	wire [31:0] ai = x0 ? h1 : h0;
	wire [31:0] xi = x0 ? h0 : h1;
	wire ai_go = (issue0 & ~x0) | (issue1 & ~x1);
	wire xi_go = (issue0 & x0) | (issue1 & x1);
	wire [1:0] pops = {1'b0, issue0} + {1'b0, issue1};

	// Arithmetic evaluation at issue; the result rides down the pipe
	reg [63:0] oa, ob, oo, ar, sa, sb;
	reg [1:0] awm;
	reg [5:0] ac;
	reg accw, accv, dbl, fp, an, bn, az, bz, lt, eq, un;
	always @* begin
		oa = fp_clock_ratio_field[ai[`FPU_I_FS]];
		ob = fp_clock_ratio_field[ai[`FPU_I_FT]];
		oo = fp_clock_ratio_field[ai[`FPU_I_FD]];
		dbl = ai[`FPU_I_FMT] == `FPU_FMT_D;
		fp = ai[`FPU_I_FMT] == `FPU_FMT_S || dbl;
		sa = dbl ? oa : {oa[31:0], 32'h0};
		sb = dbl ? ob : {ob[31:0], 32'h0};
		an = dbl ? (&oa[62:52] & |oa[51:0]) : (&oa[30:23] & |oa[22:0]);
		bn = dbl ? (&ob[62:52] & |ob[51:0]) : (&ob[30:23] & |ob[22:0]);
		az = sa[62:0] == 63'h0;
		bz = sb[62:0] == 63'h0;
		un = an | bn;
		eq = (sa == sb) | (az & bz);
		if (az & bz)
			lt = 1'b0;
		else if (sa[63] != sb[63])
			lt = sa[63];
		else
			lt = sa[63] ? (sa[62:0] > sb[62:0]) : (sa[62:0] < sb[62:0]);
		ar = oo;
		awm = dbl ? `FPU_WM_FULL : `FPU_WM_LOW;
		ac = 6'h0;
		accw = 1'b0;
		accv = 1'b0;
		case (ai[`FPU_I_OP])
		`FPU_OP_MOV: begin
			ar = oa;
			awm = ai[`FPU_I_FMT] == `FPU_FMT_D || ai[`FPU_I_FMT] == `FPU_FMT_L ?
				`FPU_WM_FULL : `FPU_WM_LOW;
		end
		`FPU_OP_NEG, `FPU_OP_ABS: begin
			ar = dbl ? (oa ^ `FPU_SIGN_D) : ((oa ^ `FPU_SIGN_S) & 64'h0000_0000_ffff_ffff);
			if (ai[`FPU_I_OP] == `FPU_OP_ABS)
				ar = ar & ~(dbl ? `FPU_SIGN_D : `FPU_SIGN_S);
			ac[`FPU_CAUSE_E] = !fp;
		end
		`FPU_OP_CMP: begin
			awm = `FPU_WM_NONE;
			accw = fp;
			case (ai[`FPU_I_COND])
			`FPU_CMP_EQ: accv = eq & ~un;
			`FPU_CMP_LT: accv = lt & ~un;
			`FPU_CMP_LE: accv = (lt | eq) & ~un;
			default: accv = un;
			endcase
			ac[`FPU_CAUSE_V] = un && (ai[`FPU_I_COND] == `FPU_CMP_LT ||
				ai[`FPU_I_COND] == `FPU_CMP_LE);
			ac[`FPU_CAUSE_E] = !fp;
		end
		`FPU_OP_MOVF: begin
			ar = (fcc[ai[`FPU_I_CC]] == ai[0]) ? oa : oo;
			awm = ai[`FPU_I_FMT] == `FPU_FMT_D || ai[`FPU_I_FMT] == `FPU_FMT_L ?
				`FPU_WM_FULL : `FPU_WM_LOW;
		end
		`FPU_OP_DIV: begin
			if (fp && bz && !az && !un) begin
				ac[`FPU_CAUSE_Z] = 1'b1;
				ar = dbl ? (`FPU_INF_D | (sa[63] ^ sb[63] ? `FPU_SIGN_D : 64'h0)) :
					(`FPU_INF_S | (sa[63] ^ sb[63] ? `FPU_SIGN_S : 64'h0));
			end else if (fp && (un || (az && bz))) begin
				ac[`FPU_CAUSE_V] = !un;
				ar = dbl ? `FPU_QNAN_D : `FPU_QNAN_S;
			end else
				ac[`FPU_CAUSE_E] = 1'b1;
		end
		`FPU_OP_SQRT: begin
			if (fp && (an || (sa[63] && !az))) begin
				ac[`FPU_CAUSE_V] = !an;
				ar = dbl ? `FPU_QNAN_D : `FPU_QNAN_S;
			end else
				ac[`FPU_CAUSE_E] = 1'b1;
		end
		`FPU_OP_ADD, `FPU_OP_SUB, `FPU_OP_MUL, `FPU_OP_MADD: begin
			if (fp && un)
				ar = dbl ? `FPU_QNAN_D : `FPU_QNAN_S;
			else
				ac[`FPU_CAUSE_E] = 1'b1;
		end
		default:
			ac[`FPU_CAUSE_E] = 1'b1;
		endcase
		if (ac[`FPU_CAUSE_E] && notrap) begin
			ac = 6'h0;
			ac[`FPU_CAUSE_V] = 1'b1;
			ar = dbl ? `FPU_QNAN_D : `FPU_QNAN_S;
		end
	end

	// Transfer pipe evaluation
	reg [63:0] xr;
	reg [1:0] xwm;
	reg xw32, xrd, xwr, xout;
	always @* begin
		xw32 = xi[`FPU_I_FMT] == `FPU_FMT_S || xi[`FPU_I_FMT] == `FPU_FMT_W;
		xr = fp_clock_ratio_field[xi[`FPU_I_FS]];
		xwm = `FPU_WM_NONE;
		xrd = 1'b0;
		xwr = 1'b0;
		xout = 1'b0;
		case (xi[`FPU_I_OP])
		`FPU_OP_LOAD, `FPU_OP_LOADX: begin
			xrd = 1'b1;
			xwm = xw32 ? `FPU_WM_LOW : `FPU_WM_FULL;
		end
		`FPU_OP_STORE, `FPU_OP_STOREX:
			xwr = 1'b1;
		`FPU_OP_MTC: begin
			xr = {32'h0, gpr_a};
			xwm = `FPU_WM_LOW;
		end
		`FPU_OP_MFC: begin
			xr = {32'h0, xr[31:0]};
			xout = 1'b1;
		end
		`FPU_OP_MTHC: begin
			xr = {gpr_a, 32'h0};
			xwm = `FPU_WM_HIGH;
		end
		`FPU_OP_MFHC: begin
			xr = {32'h0, xr[63:32]};
			xout = 1'b1;
		end
		default: ;
		endcase
	end

	wire ap_wb = fpu_en & ap_v[`FPU_LAST_STAGE];
	wire tp_wb = fpu_en & tp_v[`FPU_LAST_STAGE];
	wire [5:0] wb_c = ap_c[`FPU_LAST_STAGE];
	wire wb_trap = ap_wb & (wb_c[`FPU_CAUSE_E] | |(wb_c[4:0] & enables));

	always @(posedge aclk) begin
		if (!aresetn) begin
			ap_v <= 7'h0;
			tp_v <= 7'h0;
			ld_pend <= 1'b0;
			mem_re <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0;
			mem_wdata <= 64'h0;
		end else begin
			mem_re <= xi_go & xrd;
			mem_we <= xi_go & xwr;
			ld_pend <= xi_go & xrd;
			if (fpu_en) begin
				ap_v <= {ap_v[5:0], ai_go};
				tp_v <= {tp_v[5:0], xi_go};
				for (i = `FPU_LAST_STAGE; i > 0; i = i - 1) begin
					ap_dst[i] <= ap_dst[i-1];
					ap_wm[i] <= ap_wm[i-1];
					ap_d[i] <= ap_d[i-1];
					ap_c[i] <= ap_c[i-1];
					ap_cci[i] <= ap_cci[i-1];
					tp_dst[i] <= tp_dst[i-1];
					tp_wm[i] <= tp_wm[i-1];
					tp_d[i] <= tp_d[i-1];
				end
				ap_ccw <= {ap_ccw[5:0], accw};
				ap_ccv <= {ap_ccv[5:0], accv};
				tp_x <= {tp_x[5:0], xout};
				ap_dst[0] <= ai[`FPU_I_FD];
				ap_wm[0] <= awm;
				ap_d[0] <= ar;
				ap_c[0] <= ac;
				ap_cci[0] <= ai[`FPU_I_CC];
				tp_dst[0] <= xi[`FPU_I_FD];
				tp_wm[0] <= xwm;
				tp_d[0] <= xr;
			end
			if (xi_go) begin
				ld_w32 <= xw32;
				mem_addr <= (xi[`FPU_I_OP] == `FPU_OP_LOADX || xi[`FPU_I_OP] == `FPU_OP_STOREX) ?
					gpr_a + gpr_b : gpr_a;
				mem_wdata <= border(xw32 ? {32'h0, xr[31:0]} : xr, xw32, big_endian);
			end
			// Load data lands in whichever stage the load occupies after this edge
			if (ld_pend)
				tp_d[fpu_en ? 1 : 0] <= border(mem_rdata, ld_w32, big_endian);
		end
	end

	always @(posedge aclk) begin
		if (ap_wb && !wb_trap)
			fp_clock_ratio_field[ap_dst[`FPU_LAST_STAGE]] <= wmerge(fp_clock_ratio_field[ap_dst[`FPU_LAST_STAGE]],
				ap_d[`FPU_LAST_STAGE], ap_wm[`FPU_LAST_STAGE]);
		if (tp_wb)
			fp_clock_ratio_field[tp_dst[`FPU_LAST_STAGE]] <= wmerge(fp_clock_ratio_field[tp_dst[`FPU_LAST_STAGE]],
				tp_d[`FPU_LAST_STAGE], tp_wm[`FPU_LAST_STAGE]);
	end

	wire [31:0] fcs = {fcc[7:1], notrap, fcc[0], 5'h0, cause, enables, flags, rm};
	wire do_wr = aw_held && w_held && !bvalid &&
		!(aw_a == `FPU_A_INSTR && q_cnt == `FPU_Q_FULL);
	wire [31:0] fcs_w = smerge(fcs, w_d, w_s);
	wire [31:0] env_w = smerge(fcs & {20'h0, 5'h1f, 5'h0, 2'h3}, w_d, w_s);
	wire wr_fcs = do_wr && aw_a == `FPU_A_FCS;
	wire wr_env = do_wr && aw_a == `FPU_A_FENV;

	// Scoreboard, queue and control state
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 32'h0;
			q_rd <= 2'h0;
			q_wr <= 2'h0;
			q_cnt <= 3'h0;
			gpr_a <= 32'h0;
			gpr_b <= 32'h0;
			xfer_out <= 32'h0;
			fcc <= 8'h0;
			rm <= `FPU_RM_NEAREST_EVEN;
			flags <= 5'h0;
			enables <= 5'h0;
			cause <= 6'h0;
			notrap <= 1'b0;
			fp_exception <= 1'b0;
		end else begin
			busy <= (busy & ~({31'h0, ap_wb} << ap_dst[`FPU_LAST_STAGE]) &
				~({31'h0, tp_wb} << tp_dst[`FPU_LAST_STAGE])) |
				({31'h0, ai_go && awm != `FPU_WM_NONE} << ai[`FPU_I_FD]) |
				({31'h0, xi_go && xwm != `FPU_WM_NONE} << xi[`FPU_I_FD]);
			if (do_wr && aw_a == `FPU_A_INSTR) begin
				queue[q_wr] <= w_d;
				q_wr <= q_wr + 2'h1;
			end
			q_rd <= q_rd + pops;
			q_cnt <= q_cnt + {2'h0, do_wr && aw_a == `FPU_A_INSTR} - {1'b0, pops};
			if (do_wr && aw_a == `FPU_A_GPR_A)
				gpr_a <= smerge(gpr_a, w_d, w_s);
			if (do_wr && aw_a == `FPU_A_GPR_B)
				gpr_b <= smerge(gpr_b, w_d, w_s);
			if (tp_wb && tp_x[`FPU_LAST_STAGE])
				xfer_out <= tp_d[`FPU_LAST_STAGE][31:0];
			if (wr_fcs) begin
				rm <= fcs_w[`FPU_FCS_RM];
				enables <= fcs_w[`FPU_FCS_EN];
				cause <= fcs_w[`FPU_FCS_CAUSE];
				notrap <= fcs_w[`FPU_FCS_NOTRAP];
			end else if (wr_env) begin
				rm <= env_w[`FPU_FCS_RM];
				enables <= env_w[`FPU_FCS_EN];
			end
			// cause and sticky flags; hardware set wins
			flags <= (wr_fcs ? fcs_w[`FPU_FCS_FLAGS] : flags) |
				((ap_wb && !wb_trap) ? wb_c[4:0] : 5'h0);
			if (ap_wb)
				cause <= wb_c;
			fp_exception <= (fp_exception & ~wr_fcs) | wb_trap;
			for (j = 0; j < 8; j = j + 1) begin
				if (ap_wb && !wb_trap && ap_ccw[`FPU_LAST_STAGE] && ap_cci[`FPU_LAST_STAGE] == j)
					fcc[j] <= ap_ccv[`FPU_LAST_STAGE];
				else if (wr_fcs)
					fcc[j] <= (j == 0) ? fcs_w[`FPU_FCS_FCC0] : fcs_w[25 + j - 1];
			end
		end
	end

	// AXI4-Lite write channel: one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `FPU_RESP_OKAY;
			aw_a <= 8'h0;
			w_d <= 32'h0;
			w_s <= 4'h0;
		end else begin
			awready <= !aw_held && !(awvalid && awready) && !bvalid;
			wready <= !w_held && !(wvalid && wready) && !bvalid;
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_a <= {awaddr[7:2], 2'h0};
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_d <= wdata;
				w_s <= wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (aw_a == `FPU_A_INSTR || aw_a == `FPU_A_GPR_A || aw_a == `FPU_A_GPR_B ||
					wr_fcs || wr_env) ? `FPU_RESP_OKAY : `FPU_RESP_SLVERR;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	reg [31:0] rmux;
	reg rok;
	always @* begin
		rok = 1'b1;
		case ({araddr[7:2], 2'h0})
		`FPU_A_GPR_A: rmux = gpr_a;
		`FPU_A_GPR_B: rmux = gpr_b;
		`FPU_A_XFER: rmux = xfer_out;
		`FPU_A_STATUS: rmux = {25'h0, fp_exception, |ap_v, |tp_v | ld_pend, 1'b0, q_cnt};
		`FPU_A_CONFIG: rmux = `FPU_CFG_F64 | {30'h0, CLK_RATIO};
		`FPU_A_FCS: rmux = fcs;
		`FPU_A_FENV: rmux = fcs & {20'h0, 5'h1f, 5'h0, 2'h3};
		default: begin
			rmux = 32'h0;
			rok = 1'b0;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `FPU_RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rmux;
				rresp <= rok ? `FPU_RESP_OKAY : `FPU_RESP_SLVERR;
			end else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end
endmodule

// ### design/fpu_regs.vh
/*
 Constants of the floating point coprocessor: register offsets, field
 positions, instruction encoding, operation codes and timing counts.
 Assumes inclusion by the design file only; holds definitions, no logic.
*/
`ifndef FPU_REGS_VH
`define FPU_REGS_VH
`define FPU_A_INSTR 8'h00
`define FPU_A_GPR_A 8'h04
`define FPU_A_GPR_B 8'h08
`define FPU_A_XFER 8'h0c
`define FPU_A_STATUS 8'h10
`define FPU_A_CONFIG 8'h14
`define FPU_A_FCS 8'h18
`define FPU_A_FENV 8'h1c
`define FPU_RESP_OKAY 2'h0
`define FPU_RESP_SLVERR 2'h2
`define FPU_FCS_RM 1:0
`define FPU_FCS_FLAGS 6:2
`define FPU_FCS_EN 11:7
`define FPU_FCS_CAUSE 17:12
`define FPU_FCS_FCC0 23
`define FPU_FCS_NOTRAP 24
`define FPU_FCS_FCCHI 31:25
`define FPU_CAUSE_I 0
`define FPU_CAUSE_U 1
`define FPU_CAUSE_O 2
`define FPU_CAUSE_Z 3
`define FPU_CAUSE_V 4
`define FPU_CAUSE_E 5
`define FPU_RM_NEAREST_EVEN 2'h0
`define FPU_RM_TOWARD_ZERO 2'h1
`define FPU_RM_TOWARD_PLUS 2'h2
`define FPU_RM_TOWARD_MINUS 2'h3
`define FPU_RATIO_FULL 2'h0
`define FPU_RATIO_TWO_THIRDS 2'h1
`define FPU_RATIO_HALF 2'h2
`define FPU_CFG_HAS_PS 32'h0000_0004
`define FPU_CFG_HAS_3D 32'h0000_0008
`define FPU_CFG_F64 32'h0000_0010
`define FPU_I_XFER 31
`define FPU_I_OP 31:27
`define FPU_I_FMT 26:25
`define FPU_I_FD 24:20
`define FPU_I_FS 19:15
`define FPU_I_FT 14:10
`define FPU_I_FR 9:5
`define FPU_I_CC 4:2
`define FPU_I_COND 1:0
`define FPU_FMT_S 2'h0
`define FPU_FMT_D 2'h1
`define FPU_FMT_W 2'h2
`define FPU_FMT_L 2'h3
`define FPU_OP_ADD 5'h00
`define FPU_OP_SUB 5'h01
`define FPU_OP_MUL 5'h02
`define FPU_OP_DIV 5'h03
`define FPU_OP_SQRT 5'h04
`define FPU_OP_MADD 5'h05
`define FPU_OP_CVT 5'h06
`define FPU_OP_MOV 5'h07
`define FPU_OP_NEG 5'h08
`define FPU_OP_ABS 5'h09
`define FPU_OP_CMP 5'h0a
`define FPU_OP_MOVF 5'h0b
`define FPU_OP_LOAD 5'h10
`define FPU_OP_STORE 5'h11
`define FPU_OP_LOADX 5'h12
`define FPU_OP_STOREX 5'h13
`define FPU_OP_MTC 5'h14
`define FPU_OP_MFC 5'h15
`define FPU_OP_MTHC 5'h16
`define FPU_OP_MFHC 5'h17
`define FPU_CMP_EQ 2'h0
`define FPU_CMP_LT 2'h1
`define FPU_CMP_LE 2'h2
`define FPU_CMP_UN 2'h3
`define FPU_WM_NONE 2'h0
`define FPU_WM_LOW 2'h1
`define FPU_WM_HIGH 2'h2
`define FPU_WM_FULL 2'h3
`define FPU_LAST_STAGE 6
`define FPU_Q_FULL 3'h4
`define FPU_QNAN_S 64'h0000_0000_7fc0_0000
`define FPU_QNAN_D 64'h7ff8_0000_0000_0000
`define FPU_INF_S 64'h0000_0000_7f80_0000
`define FPU_INF_D 64'h7ff0_0000_0000_0000
`define FPU_SIGN_S 64'h0000_0000_8000_0000
`define FPU_SIGN_D 64'h8000_0000_0000_0000
`endif

// ### bench/fpu_top_asserts.sv
/*
 Checker for the coprocessor top: bus answers, holds, reset state,
 memory strobes and trap release. Assumes a bind to fpu_top.
*/
`timescale 1ns/100ps
module fpu_top_asserts (
	input logic aclk, // clock
	input logic aresetn, // reset, low
	input logic [7:0] awaddr, // aw addr
	input logic awvalid, // aw valid
	input logic awready, // aw ready
	input logic wvalid, // w valid
	input logic wready, // w ready
	input logic [1:0] bresp, // b resp
	input logic bvalid, // b valid
	input logic bready, // b ready
	input logic arvalid, // ar valid
	input logic arready, // ar ready
	input logic [31:0] rdata, // r data
	input logic rvalid, // r valid
	input logic rready, // r ready
	input logic mem_re, // load strobe
	input logic mem_we, // store strobe
	input logic fp_exception // trap
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rd_ans; arvalid && arready |=> rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_ans;
		awvalid && awready && wvalid && wready && awaddr[7:2] != 6'h00 |-> ##2 bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	property p_ar_block; rvalid |-> !arready ##1 !arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read overlap");
	property p_mem_excl; mem_re |-> !mem_we; endproperty
	a_mem_excl: assert property (p_mem_excl) else $error("load and store together");
	property p_rst;
		disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !mem_re && !mem_we && !fp_exception;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	property p_exc_fall; $fell(fp_exception) |-> bvalid || $past(bvalid); endproperty
	a_exc_fall: assert property (p_exc_fall) else $error("trap fell without write");
	c_trap: cover property ($rose(fp_exception));
	c_err: cover property (bvalid && bresp == 2'h2);
	c_load: cover property (mem_re);
endmodule

// ### bench/fpu_mem_model.sv
/*
 Memory partner for the load/store pipe. Assumes one-cycle strobes and
 addresses below 64 KiB; answers within the load strobe's own cycle,
 scrambled data otherwise.
*/
`timescale 1ns/100ps
module fpu_mem_model (
	input logic aclk, // clock
	input logic mem_re, // load strobe
	input logic mem_we, // store strobe
	input logic [31:0] mem_addr, // byte address
	input logic [63:0] mem_wdata, // store lanes
	output logic [63:0] mem_rdata, // load lanes
	output logic [63:0] last_wdata // last store seen
);
	logic [63:0] mem [0:8191];
	logic [8191:0] seen = '0;
	logic [63:0] pat = 64'h0;
	initial last_wdata = 64'h0;
	always @(posedge aclk) begin
		pat <= {pat[62:0], ~pat[63]};
		if (mem_we) begin
			mem[mem_addr[15:3]] <= mem_wdata;
			seen[mem_addr[15:3]] <= 1'b1;
			last_wdata <= mem_wdata;
		end
	end
	// The unit takes load data at the edge that closes the strobe cycle
	// Outside that cycle the lanes keep changing, so stale use shows
	always_comb begin
		if (mem_re && seen[mem_addr[15:3]])
			mem_rdata = mem[mem_addr[15:3]];
		else
			mem_rdata = ~pat;
	end
endmodule

// ### bench/tb_floating_point_unit.sv
/*
 Self-checking bench for the coprocessor: bus tasks, random operands,
 memory partner. Assumes the unit built at full clock ratio.
*/
`timescale 1ns/100ps
bind fpu_top fpu_top_asserts fpu_top_asserts_inst (.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rvalid(rvalid), .rready(rready), .mem_re(mem_re), .mem_we(mem_we),
	.fp_exception(fp_exception));
module tb_floating_point_unit;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, big_endian;
	logic awready, wready, bvalid, arready, rvalid, mem_re, mem_we, fp_exception;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, mem_addr, s, a;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [63:0] mem_wdata, mem_rdata, last_wdata, v, w;
	int num_errors = 0, num_checks = 0, seed = 7, i;
	fpu_top #(.CLK_RATIO(2'h0)) fpu_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .big_endian(big_endian), .mem_re(mem_re), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.fp_exception(fp_exception));
	fpu_mem_model fpu_mem_model_inst (.aclk(aclk), .mem_re(mem_re), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.last_wdata(last_wdata));
	task automatic complete_run();
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [63:0] swap8(input logic [63:0] x);
		for (int k = 0; k < 8; k++) swap8[8*k +: 8] = x[8*(7-k) +: 8];
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] ad);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		s = rdata;
		r = rresp;
	endtask
	// Push one double-format instruction, then poll until queue and pipes drain
	task automatic ex(input logic [4:0] op, fd, fs, ft, cc);
		wr(8'h00, {op, 2'h1, fd, fs, ft, 5'h00, cc});
		s = 32'h1;
		while (s[5:0] !== 6'h00) rd(8'h10);
	endtask
	task automatic put(input logic [4:0] fd, input logic [63:0] x);
		wr(8'h04, x[31:0]);
		ex(5'h14, fd, 5'h0, 5'h0, 5'h0);
		wr(8'h04, x[63:32]);
		ex(5'h16, fd, 5'h0, 5'h0, 5'h0);
	endtask
	task automatic get(input logic [4:0] fs, output logic [63:0] x);
		ex(5'h15, 5'h0, fs, 5'h0, 5'h0);
		rd(8'h0c);
		x[31:0] = s;
		ex(5'h17, 5'h0, fs, 5'h0, 5'h0);
		rd(8'h0c);
		x[63:32] = s;
	endtask
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		repeat (60000) @(posedge aclk);
		num_errors++;
		complete_run();
	end
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		big_endian = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h14);
		chk("config", s, 32'h10);
		for (i = 0; i < 4; i++) begin
			wr(8'h18, i);
			rd(8'h18);
			chk("round_mode", s[1:0], i[1:0]);
		end
		a = $random(seed);
		wr(8'h18, {20'h0, a[4:0], 7'h0});
		rd(8'h1c);
		chk("enables_view", s[11:7], a[4:0]);
		wr(8'h1c, {20'h0, a[9:5], 7'h0});
		rd(8'h18);
		chk("control_enables", s[11:7], a[9:5]);
		wr(8'h18, 32'h0);
		rd(8'h20);
		chk("unmapped_read", {r, s}, 34'h2_0000_0000);
		wr(8'h14, a);
		chk("readonly_write", r, 2'h2);
		for (i = 0; i < 2; i++) begin
			v = {$random(seed), $random(seed)};
			a = $random(seed) & 32'h0000_fff8;
			big_endian <= i[0];
			put(5'h1, v);
			get(5'h1, w);
			chk("transfer_pair", w, v);
			wr(8'h04, a);
			ex(5'h11, 5'h0, 5'h1, 5'h0, 5'h0);
			chk("store_lanes", last_wdata, i ? swap8(v) : v);
			wr(8'h04, a - 32'h10);
			wr(8'h08, 32'h10);
			ex(5'h12, 5'h2, 5'h0, 5'h0, 5'h0);
			get(5'h2, w);
			chk("indexed_load", w, v);
		end
		big_endian <= 1'b0;
		a = $random(seed);
		v = {12'h3ff, 20'h0, a};
		put(5'h1, v);
		// Equal-compare is true and less-than is false for a value against itself
		for (i = 0; i < 8; i++) begin
			ex(5'h0a, 5'h0, 5'h1, 5'h1, {i[2:0], 1'b0, i[0]});
			rd(8'h18);
			chk("cond_flag", i ? s[24 + i] : s[23], !i[0]);
		end
		put(5'h3, 64'h0);
		v[63] = a[31];
		put(5'h1, v);
		ex(5'h03, 5'h4, 5'h1, 5'h3, 5'h0);
		get(5'h4, w);
		chk("div_zero_result", w, {a[31], 63'h7ff0_0000_0000_0000});
		rd(8'h18);
		chk("div_zero_flag", {fp_exception, s[5]}, 2'b01);
		w = {$random(seed), $random(seed)};
		put(5'h5, w);
		wr(8'h18, 32'h0000_0400);
		ex(5'h03, 5'h5, 5'h1, 5'h3, 5'h0);
		rd(8'h18);
		chk("trap_cause", {fp_exception, s[15]}, 2'b11);
		wr(8'h18, 32'h0);
		@(posedge aclk);
		chk("trap_release", fp_exception, 1'b0);
		get(5'h5, v);
		chk("trap_no_write", v, w);
		complete_run();
	end
endmodule
